// ===== shared/rst_ctl_pkg.sv
// constants and types shared by the reset controller
package rst_ctl_pkg;
    // ****************************************
    // timing
    // ****************************************
    localparam int unsigned CLK_MHZ         = 125;
    localparam int unsigned STRETCH_CYCLES  = 512;
    localparam int unsigned RISE_CYCLES     = 14;
    localparam int unsigned MIN_EXT_PERIODS = 590;
    localparam int unsigned CNT_W           = 10;
    localparam logic [9:0]  STRETCH_CNT     = 10'(STRETCH_CYCLES);
    localparam logic [9:0]  RISE_CNT        = 10'(RISE_CYCLES);
    localparam logic [9:0]  CNT_ZERO        = 10'h000;
    // blanks the pin input while our own drive drains out of the synchroniser
    localparam logic [9:0]  SETTLE_CNT      = 10'h003;

    // ****************************************
    // sequencer states
    // ****************************************
    typedef enum logic [2:0] {
        ST_RUN,
        ST_WAIT_BUS,
        ST_ASSERT,
        ST_PIN_HELD,
        ST_STRETCH,
        ST_RISE,
        ST_SAMPLE,
        ST_INSTR
    } seq_state_e;
endpackage

// ===== hw/sync2.sv
// two-flop synchroniser for a pin level
`timescale 1ns/1ps
`default_nettype none
module sync2
(
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic ce_i,
    input  wire logic rst_val_i,
    input  wire logic d_i,
    output logic      q_o
);
    logic meta;
    logic next_meta;
    logic next_q;

    always_comb
    begin
        next_meta = meta;
        next_q    = q_o;
        if (!rst_n_i)
        begin
            next_meta = rst_val_i;
            next_q    = rst_val_i;
        end
        else if (ce_i)
        begin
            next_meta = d_i;
            next_q    = meta;
        end
    end

    // reset level is chosen by the user so no false edge follows reset
    always_ff @(posedge clk_i)
    begin
        meta <= next_meta;
        q_o  <= next_q;
    end
endmodule
`default_nettype wire

// ===== hw/mcu_reset_controller.sv
// reset cause detection, stretching and bus sequencing for the controller
`timescale 1ns/1ps
`default_nettype none
// How it works
// - three reset outputs: pin drive, clock unit, core logic; clock unit reset asserts only with core reset
// - each source class selects sync/async timing and which lines assert
// - synchronous sources wait for bus cycle end, even during locked rmw
// - synchronous reset forces bus monitor on to end a stuck cycle
// - only byte or aligned word writes are guaranteed under sync reset
// - external writes complete if outside mode logic is gated by read/write
// - asynchronous sources apply reset immediately
// - reset pin passes a two-flop synchroniser before use
// - while pin held low keep core reset, then drive pin 512 more cycles
// - other sources drive pin at least 512 cycles and while source asserted
// - after internal reset wait 14 cycles, sample pin, then vector fetch
// - bus tri-stated during reset, untristatable signals held inactive
// - on reset exit drive controls inactive, data read, address driven
// - reset ends bus cycle as if acknowledged, registers take reset values
// - reset instruction drives pin 512 cycles, internal state untouched
// - halt monitor may request reset; double fault halt ends only by reset
module mcu_reset_controller
    import rst_ctl_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic ce_i,
    input  wire logic reset_pin_i,          // pin level, low = asserted
    input  wire logic power_up_req_i,
    input  wire logic watchdog_req_i,
    input  wire logic halt_monitor_req_i,
    input  wire logic loss_of_clock_req_i,
    input  wire logic test_req_i,
    input  wire logic reset_instr_req_i,    // one-cycle pulse from the core
    input  wire logic bus_cycle_end_i,
    input  wire logic locked_rmw_indicator,
    output logic      ext_pin_reset_drive,  // high = drive pin low
    output logic      reset_pin_oe_o,
    output logic      reset_pin_o,
    output logic      clock_unit_reset,
    output logic      core_logic_reset,
    output logic      bus_monitor_force_o,
    output logic      bus_tristate_o,
    output logic      bus_ctrl_inactive_o,
    output logic      cycle_abort_o,
    output logic      vector_fetch_o
);
    // ****************************************
    // pin synchroniser
    // ****************************************
    logic pin_sync;

    sync2 u_pin_sync
    (
        .clk_i     (clk_i),
        .rst_n_i   (rst_n_i),
        .ce_i      (ce_i),
        .rst_val_i (1'b1),
        .d_i       (reset_pin_i),
        .q_o       (pin_sync)
    );

    wire logic pin_low = ~pin_sync;
    wire logic async_src = power_up_req_i | watchdog_req_i | halt_monitor_req_i;
    wire logic sync_src  = loss_of_clock_req_i | test_req_i;
    wire logic any_src   = async_src | sync_src;

    // ****************************************
    // sequencer
    // ****************************************
    seq_state_e state;
    seq_state_e next_state;
    logic [9:0] cnt;
    logic [9:0] next_cnt;
    logic       clk_line;
    logic       next_clk_line;
    logic       src_seen;
    logic       next_src_seen;
    logic       next_pin_drive;
    logic       next_core;
    logic       next_clk_rst;
    logic       next_bmon;
    logic       next_tri;
    logic       next_inact;
    logic       next_abort;
    logic       next_fetch;
    // after the instruction drive the pin still reads low for two cycles
    wire logic  pin_ext = pin_low & (cnt == CNT_ZERO);

    always_comb
    begin
        next_state    = state;
        next_cnt      = cnt;
        next_clk_line = clk_line;
        next_src_seen = any_src;
        next_abort    = 1'b0;
        next_fetch    = 1'b0;
        if (cnt != CNT_ZERO)
        begin
            next_cnt = cnt - 10'h001;
        end
        case (state)
            ST_RUN:
            begin
                next_clk_line = 1'b0;
                if (async_src)
                begin
                    next_clk_line = 1'b1;
                    next_state    = ST_ASSERT;
                    next_abort    = 1'b1;
                    next_cnt      = STRETCH_CNT;
                end
                else if (pin_ext | sync_src)
                begin
                    // test reset leaves the clock unit running
                    next_clk_line = pin_ext | loss_of_clock_req_i;
                    next_state    = ST_WAIT_BUS;
                end
                else if (reset_instr_req_i)
                begin
                    next_state = ST_INSTR;
                    next_cnt   = STRETCH_CNT;
                end
            end
            ST_WAIT_BUS:
            begin
                // bus monitor is forced on here; rmw lock does not delay us
                // an async source does not wait for the bus
                if (bus_cycle_end_i || async_src)
                begin
                    next_state    = ST_ASSERT;
                    next_abort    = 1'b1;
                    next_cnt      = STRETCH_CNT;
                    next_clk_line = clk_line | async_src;
                end
            end
            ST_ASSERT:
            begin
                if (pin_low & ~ext_pin_reset_drive)
                begin
                    next_state = ST_PIN_HELD;
                end
                else
                begin
                    next_state = ST_STRETCH;
                    next_cnt   = STRETCH_CNT;
                end
            end
            ST_PIN_HELD:
            begin
                next_cnt = STRETCH_CNT;
                if (!pin_low)
                begin
                    next_state = ST_STRETCH;
                end
            end
            ST_STRETCH:
            begin
                if (any_src & ~src_seen)
                begin
                    next_cnt = STRETCH_CNT;
                end
                else if (any_src)
                begin
                    next_cnt = cnt; // hold while a source stays asserted
                end
                else if (cnt == 10'h001 || cnt == CNT_ZERO)
                begin
                    next_state = ST_RISE;
                    next_cnt   = RISE_CNT;
                end
            end
            ST_RISE:
            begin
                if (cnt == 10'h001 || cnt == CNT_ZERO)
                begin
                    next_state = ST_SAMPLE;
                end
            end
            ST_SAMPLE:
            begin
                if (pin_low)
                begin
                    next_state = ST_PIN_HELD; // external reset seen
                end
                else
                begin
                    next_state    = ST_RUN;
                    next_fetch    = 1'b1;
                    next_clk_line = 1'b0;
                end
            end
            ST_INSTR:
            begin
                if (async_src)
                begin
                    next_state    = ST_ASSERT;
                    next_clk_line = 1'b1;
                    next_abort    = 1'b1;
                    next_cnt      = STRETCH_CNT;
                end
                else if (cnt == 10'h001 || cnt == CNT_ZERO)
                begin
                    next_state = ST_RUN;
                    next_cnt   = SETTLE_CNT;
                end
            end
            default:
            begin
                next_state = ST_RUN;
            end
        endcase

        // outputs, registered from the next state
        next_pin_drive = (next_state == ST_STRETCH) || (next_state == ST_INSTR);
        next_core      = (next_state != ST_RUN) && (next_state != ST_INSTR)
                      && (next_state != ST_WAIT_BUS);
        next_clk_rst   = next_core & next_clk_line;
        next_bmon      = (next_state == ST_WAIT_BUS);
        next_tri       = next_core;
        next_inact     = next_core | next_fetch;

        if (!rst_n_i)
        begin
            next_state     = ST_RUN;
            next_cnt       = CNT_ZERO;
            next_clk_line  = 1'b0;
            next_src_seen  = 1'b0;
            next_pin_drive = 1'b0;
            next_core      = 1'b0;
            next_clk_rst   = 1'b0;
            next_bmon      = 1'b0;
            next_tri       = 1'b0;
            next_inact     = 1'b0;
            next_abort     = 1'b0;
            next_fetch     = 1'b0;
        end
        else if (!ce_i)
        begin
            next_state     = state;
            next_cnt       = cnt;
            next_clk_line  = clk_line;
            next_src_seen  = src_seen;
            next_pin_drive = ext_pin_reset_drive;
            next_core      = core_logic_reset;
            next_clk_rst   = clock_unit_reset;
            next_bmon      = bus_monitor_force_o;
            next_tri       = bus_tristate_o;
            next_inact     = bus_ctrl_inactive_o;
            next_abort     = cycle_abort_o;
            next_fetch     = vector_fetch_o;
        end
    end

    always_ff @(posedge clk_i)
    begin
        state               <= next_state;
        cnt                 <= next_cnt;
        clk_line            <= next_clk_line;
        src_seen            <= next_src_seen;
        ext_pin_reset_drive <= next_pin_drive;
        reset_pin_oe_o      <= next_pin_drive;
        reset_pin_o         <= 1'b0;
        core_logic_reset    <= next_core;
        clock_unit_reset    <= next_clk_rst;
        bus_monitor_force_o <= next_bmon;
        bus_tristate_o      <= next_tri;
        bus_ctrl_inactive_o <= next_inact;
        cycle_abort_o       <= next_abort;
        vector_fetch_o      <= next_fetch;
    end

    // ****************************************
    // checks
    // ****************************************
    property p_instr_keeps_core;
        @(posedge clk_i) disable iff (!rst_n_i)
        (state == ST_INSTR) |-> !core_logic_reset;
    endproperty
    a_instr_keeps_core: assert property (p_instr_keeps_core)
        else $error("core reset asserted during reset instruction");

    property p_wait_forces_monitor;
        @(posedge clk_i) disable iff (!rst_n_i)
        (state == ST_WAIT_BUS) && $past(state == ST_WAIT_BUS) |-> bus_monitor_force_o;
    endproperty
    a_wait_forces_monitor: assert property (p_wait_forces_monitor)
        else $error("bus monitor not forced while waiting");

    property p_async_fast;
        @(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && (state inside {ST_RUN, ST_WAIT_BUS, ST_INSTR}) && async_src)
            |=> core_logic_reset;
    endproperty
    a_async_fast: assert property (p_async_fast)
        else $error("async source not applied at once");

    property p_sync_waits;
        @(posedge clk_i) disable iff (!rst_n_i)
        (state == ST_WAIT_BUS && !bus_cycle_end_i && !async_src) |=> !cycle_abort_o;
    endproperty
    a_sync_waits: assert property (p_sync_waits)
        else $error("sync reset applied before bus cycle end");

    property p_rmw_no_delay;
        @(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && state == ST_WAIT_BUS && bus_cycle_end_i && locked_rmw_indicator)
            |=> cycle_abort_o;
    endproperty
    a_rmw_no_delay: assert property (p_rmw_no_delay)
        else $error("locked rmw delayed a sync reset");

    property p_pin_held_core;
        @(posedge clk_i) disable iff (!rst_n_i)
        (state == ST_PIN_HELD) |-> core_logic_reset && !ext_pin_reset_drive;
    endproperty
    a_pin_held_core: assert property (p_pin_held_core)
        else $error("core reset dropped while pin held");

    property p_test_no_clk;
        @(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && state == ST_RUN && test_req_i && !async_src && !pin_low
            && !loss_of_clock_req_i) |=> !clk_line;
    endproperty
    a_test_no_clk: assert property (p_test_no_clk)
        else $error("test reset selected clock unit reset");

    property p_fetch_after_rise;
        @(posedge clk_i) disable iff (!rst_n_i)
        $rose(vector_fetch_o) |-> $past(state == ST_SAMPLE);
    endproperty
    a_fetch_after_rise: assert property (p_fetch_after_rise)
        else $error("vector fetch without rise-time sample");

    property p_clk_subset;
        @(posedge clk_i) disable iff (!rst_n_i)
        clock_unit_reset |-> core_logic_reset;
    endproperty
    a_clk_subset: assert property (p_clk_subset)
        else $error("clock reset without core reset");

    property p_tri_with_core;
        @(posedge clk_i) disable iff (!rst_n_i)
        core_logic_reset |-> bus_tristate_o && bus_ctrl_inactive_o;
    endproperty
    a_tri_with_core: assert property (p_tri_with_core)
        else $error("bus not tri-stated during reset");
endmodule
`default_nettype wire

// ===== test/rst_line_partner.sv
// outside reset source and the pulled-up reset line it shares with the controller
`timescale 1ns/1ps
`default_nettype none
module rst_line_partner
    import rst_ctl_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic press_i,
    input  wire logic dut_oe_i,
    input  wire logic dut_level_i,
    output logic      pin_o
);
    int unsigned left;
    logic        drive;

    // a press is held for the full 590 periods, however short the request
    always @(posedge clk_i)
    begin
        if (press_i)
            left <= MIN_EXT_PERIODS;
        else if (left != 0)
            left <= left - 1;
    end

    assign drive = (left != 0);
    // open-drain line: the pull-up wins only when nobody pulls it low
    assign pin_o = drive ? 1'b0 : (dut_oe_i ? dut_level_i : 1'b1);
endmodule
`default_nettype wire

// ===== test/tb.sv
// self-checking bench for the reset controller
`timescale 1ns/1ps
`default_nettype none
module tb;
    import rst_ctl_pkg::*;
    logic       clk     = 1'b0;
    logic       rst_n   = 1'b0;
    logic       press   = 1'b0;
    logic       instr   = 1'b0;
    logic       bus_end = 1'b0;
    logic       rmw     = 1'b0;
    logic [4:0] src     = 5'h00;  // power, watchdog, halt, loss of clock, test
    wire logic  pin;
    logic       drv, oe, pin_out, clk_rst, core, mon, tri_s, inact, abort, fetch;
    int         n_fail      = 0;
    int         check_count = 0;
    localparam int N_STR  = int'(STRETCH_CYCLES);
    localparam int N_RISE = int'(RISE_CYCLES);

    always #4 clk = ~clk;

    rst_line_partner u_partner (.clk_i(clk), .press_i(press), .dut_oe_i(oe),
        .dut_level_i(pin_out), .pin_o(pin));

    mcu_reset_controller u_dut (
        .clk_i(clk), .rst_n_i(rst_n), .ce_i(1'b1), .reset_pin_i(pin),
        .power_up_req_i(src[0]), .watchdog_req_i(src[1]), .halt_monitor_req_i(src[2]),
        .loss_of_clock_req_i(src[3]), .test_req_i(src[4]), .reset_instr_req_i(instr),
        .bus_cycle_end_i(bus_end), .locked_rmw_indicator(rmw),
        .ext_pin_reset_drive(drv), .reset_pin_oe_o(oe), .reset_pin_o(pin_out),
        .clock_unit_reset(clk_rst), .core_logic_reset(core), .bus_monitor_force_o(mon),
        .bus_tristate_o(tri_s), .bus_ctrl_inactive_o(inact), .cycle_abort_o(abort),
        .vector_fetch_o(fetch));

    // ****************************************
    // checking and verdict
    // ****************************************
    task automatic check(string what, logic [31:0] got, logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    // k: 0..4 index into src, 5 = outside party pulls the pin
    task automatic run_src(int k);
        int   bd, hold, t, t_core, t_rel, t_drv, t_fetch;
        logic sync, saw_abort;
        sync = (k >= 3);
        bd = sync ? ((k == 5) ? 7 : 2) + $urandom % 5 : 0;
        hold = bd + 1 + $urandom % 40;
        t_core = -1;
        t_drv = -1;
        t_fetch = -1;
        t_rel = 0;
        saw_abort = 1'b0;
        rmw <= 1'($urandom % 2);
        if (k == 5)
            press <= 1'b1;
        else
            src[k] <= 1'b1;
        for (t = 1; t < 3000 && t_fetch < 0; t++)
        begin
            @(posedge clk);
            press <= 1'b0;
            bus_end <= sync && t >= bd && t_core < 0;
            if (t == hold && k < 5)
                src[k] <= 1'b0;
            if ((k < 5) ? src[k] : u_partner.drive)
                t_rel = t;
            if (sync && t == bd)
            begin
                check("held off", core, 1'b0);
                check("monitor forced", mon, 1'b1);
            end
            if (core === 1'b1 && t_core < 0)
                t_core = t;
            if (core === 1'b1)
            begin
                check("tristate", tri_s, 1'b1);
                check("clock reset", clk_rst, 32'(k != 4));
            end
            if (abort === 1'b1)
                saw_abort = 1'b1;
            if (drv === 1'b1)
                t_drv = t;
            if (fetch === 1'b1)
                t_fetch = t;
        end
        check("reset start", sync ? (t_core > bd && t_core <= bd + 3) : (t_core > 0 && t_core <= 3),
              1'b1);
        check("stretch", t_drv - t_rel >= N_STR && t_drv - t_rel <= N_STR + 5,
              1'b1);
        check("rise wait", t_fetch - t_drv >= N_RISE && t_fetch - t_drv <= N_RISE + 3,
              1'b1);
        check("aborted", saw_abort, 1'b1);
        @(posedge clk);
        check("core released", core, 1'b0);
        @(posedge clk);
        check("bus released", tri_s | inact, 1'b0);
        if (t_fetch < 0)
            summarize();
    endtask

    task automatic run_instr();
        int   t, n_drv;
        logic bad;
        n_drv = 0;
        bad = 1'b0;
        instr <= 1'b1;
        for (t = 0; t < 700; t++)
        begin
            @(posedge clk);
            instr <= 1'b0;
            if (drv === 1'b1)
            begin
                n_drv++;
                check("pin driven", pin, 1'b0);
            end
            if (core !== 1'b0 || clk_rst !== 1'b0 || fetch !== 1'b0 || mon !== 1'b0)
                bad = 1'b1;
        end
        check("instruction drive", n_drv, N_STR);
        check("instruction internal", bad, 1'b0);
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        void'($urandom(32'h7cb7));
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        for (int k = 0; k < 6; k++)
        begin
            run_src(k);
            repeat (3) @(posedge clk);
            $display("test source %0d done", k);
        end
        run_instr();
        $display("test reset instruction done");
        summarize();
    end
endmodule
`default_nettype wire
